//--- src/boot_pkg.sv
/*
 * Shared constants, types and state codes for the reset and boot loader.
 * Assumes a single 100 MHz core clock and byte-wide serial links.
 */
package boot_pkg;

    // ************************************************************
    // Sizes and addresses
    // ************************************************************
    localparam int          NUM_LINKS      = 4;
    localparam int          BYTE_W         = 8;
    localparam int          ADDR_W         = 32;
    localparam int          FIFO_DEPTH     = 8;
    localparam logic [31:0] ROM_ENTRY_ADDR = 32'hFFFF_FFFE;
    // Load base is product dependent; this value is a plain default.
    localparam logic [31:0] LOAD_BASE_ADDR = 32'h0000_0100;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS   = 10;
    localparam int LINK_RATE_MBPS  = 10;
    localparam int LINK_BIT_NS     = 1000 / LINK_RATE_MBPS;
    localparam int BIT_CYC_INT     = LINK_BIT_NS / CLK_PERIOD_NS;
    localparam int EMI_INIT_NS     = 200;
    localparam int EMI_CYC_INT     =
        (EMI_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] BIT_CYCLES   = 5'(BIT_CYC_INT);
    localparam logic [4:0] FIRST_SAMPLE = 5'(BIT_CYC_INT + BIT_CYC_INT / 2);
    localparam logic [4:0] ACK_CYCLES   = 5'(2 * BIT_CYC_INT);
    localparam logic [7:0] EMI_CYCLES   = 8'(EMI_CYC_INT);
    localparam logic [3:0] STOP_BIT_IDX = 4'h9;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        ST_INIT  = 3'b000,
        ST_WAIT  = 3'b001,
        ST_LOAD  = 3'b010,
        ST_ENTER = 3'b011,
        ST_RUN   = 3'b100
    } boot_state_t;

    typedef struct packed {
        logic overflow;
        logic bound;
        logic div_zero;
    } sw_err_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } mem_wr_t;

    typedef struct packed {
        logic [1:0]        link;
        logic [BYTE_W-1:0] data;
    } chan_byte_t;

endpackage

//--- src/boot_fifo.sv
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes one clock; the drain side may stall so the FIFO really fills.
 */
`timescale 1ns/1ps
module boot_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_ff @(posedge clk_i) begin
        if (ce_i && push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (ce_i) begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

//--- src/link_port.sv
/*
 * One serial link end: byte receiver and acknowledge sender.
 * Assumes data packets of 1,1,eight bits LSB first,0 and acks of 1,0.
 */
`timescale 1ns/1ps
module link_port
    import boot_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              ce_i,
    input  wire logic              line_i,
    input  wire logic              take_i,
    output logic                   valid_o,
    output logic [BYTE_W-1:0]      data_o,
    output logic                   line_o
);
    logic              s1_q;
    logic              s2_q;
    logic              busy_q;
    logic [4:0]        cnt_q;
    logic [3:0]        bit_q;
    logic [BYTE_W-1:0] shift_q;
    logic [4:0]        ack_q;

    // ************************************************************
    // Receive side
    // ************************************************************
    // The pin is free running against our clock, so it is resynchronised.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else if (ce_i) begin
            s1_q <= line_i;
            s2_q <= s1_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            busy_q  <= 1'b0;
            cnt_q   <= '0;
            bit_q   <= '0;
            shift_q <= '0;
            valid_o <= 1'b0;
            data_o  <= '0;
        end else if (ce_i) begin
            if (take_i) begin
                valid_o <= 1'b0;
            end
            if (!busy_q) begin
                if (s2_q) begin
                    busy_q <= 1'b1;
                    cnt_q  <= FIRST_SAMPLE - 5'h01;
                    bit_q  <= '0;
                end
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - 5'h01;
            end else begin
                cnt_q <= BIT_CYCLES - 5'h01;
                bit_q <= bit_q + 4'h1;
                if (bit_q == 4'h0 && !s2_q) begin
                    busy_q <= 1'b0;
                end else if (bit_q == STOP_BIT_IDX) begin
                    busy_q  <= 1'b0;
                    valid_o <= 1'b1;
                    data_o  <= shift_q;
                end else if (bit_q != 4'h0) begin
                    shift_q <= {s2_q, shift_q[BYTE_W-1:1]};
                end
            end
        end
    end

    // ************************************************************
    // Acknowledge side
    // ************************************************************
    // Line is high for one bit, then low for one; it idles low.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_q  <= '0;
            line_o <= 1'b0;
        end else if (ce_i) begin
            if (take_i) begin
                ack_q <= ACK_CYCLES - 5'h01;
            end else if (ack_q != '0) begin
                ack_q <= ack_q - 5'h01;
            end
            line_o <= take_i | (ack_q > BIT_CYCLES);
        end
    end
endmodule

//--- src/reset_boot_loader.sv
/*
 * Reset sequencing, boot source choice, link program loader and error
 * latch for one processor node.
 * Assumes the processor core, memory and error sources sit on the same
 * clock, and that link pins and the event pin are asynchronous.
 */
// How it works
// - Processor and links start once reset ends
// - Memory interface initialised while reset sequence runs
// - ROM boot enters at top two bytes
// - First link with message becomes boot link
// - First boot byte is program byte count
// - Store bytes from load base, then jump
// - Other links unacknowledged until process inputs them
// - Software errors set the error flag
// - Error pin follows the flag directly
// - Error either ignored or halts execution
// - Link outputs idle low
// - Each link is two one-way wires
// - Links run at ten megabits per second
// - Single clock; link timing derived from it
// - Link inputs sampled asynchronously
// - Event input requests processor attention
`timescale 1ns/1ps
module reset_boot_loader
    import boot_pkg::*;
(
    input  wire logic                 CORE_CLK_I,
    input  wire logic                 RST_N_I,
    input  wire logic                 CE_I,
    input  wire logic                 BOOT_FROM_LINK_I,
    input  wire logic [NUM_LINKS-1:0] LINK_IN_I,
    output logic      [NUM_LINKS-1:0] LINK_OUT_O,
    input  wire logic [NUM_LINKS-1:0] LINK_INPUT_REQ_I,
    output logic                      CHAN_VALID_O,
    output chan_byte_t                CHAN_BYTE_O,
    output logic                      EMI_INIT_O,
    output logic                      LINKS_EN_O,
    output logic                      PROC_RUN_O,
    output logic                      START_O,
    output logic [ADDR_W-1:0]         START_ADDR_O,
    output logic                      MEM_WR_VALID_O,
    input  wire logic                 MEM_WR_READY_I,
    output mem_wr_t                   MEM_WR_O,
    input  wire sw_err_t              SW_ERR_I,
    input  wire logic                 ERR_CLR_I,
    input  wire logic                 HALT_ON_ERR_I,
    output logic                      ERROR_O,
    output logic                      PROC_HALT_O,
    input  wire logic                 EVENT_REQ_I,
    output logic                      EVENT_O
);

    // ************************************************************
    // Declarations
    // ************************************************************
    boot_state_t                   state_q;
    logic [7:0]                    emi_cnt_q;
    logic                          strap_s1_q;
    logic                          strap_s2_q;
    logic                          link_boot_q;
    logic                          ev_s1_q;
    logic                          ev_s2_q;
    logic                          ev_s3_q;
    logic [1:0]                    boot_link_q;
    logic [BYTE_W-1:0]             left_q;
    logic [ADDR_W-1:0]             wr_addr_q;
    logic                          err_q;
    logic [NUM_LINKS-1:0]          rx_valid;
    logic [BYTE_W-1:0]             rx_data [NUM_LINKS];
    logic [NUM_LINKS-1:0]          take;
    logic [NUM_LINKS-1:0]          first_oh;
    logic [NUM_LINKS-1:0]          run_oh;
    logic [1:0]                    first_idx;
    logic [1:0]                    run_idx;
    logic                          fifo_in_valid;
    logic                          fifo_in_ready;
    logic                          fifo_out_valid;
    logic [BYTE_W-1:0]             fifo_out_data;
    logic                          mem_fire;
    logic                          any_err;

    // ************************************************************
    // Link ports
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_LINKS; g++) begin : g_link
            link_port u_port (
                .clk_i   (CORE_CLK_I),
                .rst_n_i (RST_N_I),
                .ce_i    (CE_I),
                .line_i  (LINK_IN_I[g]),
                .take_i  (take[g]),
                .valid_o (rx_valid[g]),
                .data_o  (rx_data[g]),
                .line_o  (LINK_OUT_O[g])
            );

            // Taking a byte is what sends its acknowledge.
            always_comb begin
                take[g] = 1'b0;
                unique case (state_q)
                    ST_WAIT: take[g] = first_oh[g];
                    ST_LOAD: take[g] = rx_valid[g] &&
                                       (boot_link_q == 2'(g)) &&
                                       fifo_in_ready && (left_q != '0);
                    ST_RUN:  take[g] = run_oh[g];
                    ST_INIT,
                    ST_ENTER: take[g] = 1'b0;
                endcase
            end
        end
    endgenerate

    // ************************************************************
    // Arbitration between links
    // ************************************************************
    // The lowest numbered link wins a tie within one clock.
    always_comb begin
        first_oh  = '0;
        first_idx = '0;
        for (int i = NUM_LINKS - 1; i >= 0; i--) begin
            if (rx_valid[i]) begin
                first_oh  = '0;
                first_oh[i] = 1'b1;
                first_idx = 2'(i);
            end
        end
    end

    // Once running, a link is taken only while a process inputs from it.
    always_comb begin
        run_oh  = '0;
        run_idx = '0;
        for (int i = NUM_LINKS - 1; i >= 0; i--) begin
            if (rx_valid[i] && LINK_INPUT_REQ_I[i]) begin
                run_oh  = '0;
                run_oh[i] = 1'b1;
                run_idx = 2'(i);
            end
        end
    end

    // ************************************************************
    // Program buffer
    // ************************************************************
    // A full buffer stops the take, so the sender waits for its ack.
    assign fifo_in_valid = (state_q == ST_LOAD) && (left_q != '0) &&
                           rx_valid[boot_link_q];

    boot_fifo #(
        .W     (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (CORE_CLK_I),
        .rst_n_i     (RST_N_I),
        .ce_i        (CE_I),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (rx_data[boot_link_q]),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (MEM_WR_READY_I),
        .out_data_o  (fifo_out_data)
    );

    assign MEM_WR_VALID_O = fifo_out_valid;
    assign MEM_WR_O.addr  = wr_addr_q;
    assign MEM_WR_O.data  = fifo_out_data;
    assign mem_fire       = fifo_out_valid & MEM_WR_READY_I;

    // Consecutive addresses from the load base.
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            wr_addr_q <= LOAD_BASE_ADDR;
        end else if (CE_I && mem_fire) begin
            wr_addr_q <= wr_addr_q + 32'h0000_0001;
        end
    end

    // ************************************************************
    // Boot strap
    // ************************************************************
    // The strap pin is resynchronised and captured only while reset is
    // low, so a late change after release cannot alter the boot path.
    always_ff @(posedge CORE_CLK_I) begin
        if (CE_I) begin
            strap_s1_q <= BOOT_FROM_LINK_I;
            strap_s2_q <= strap_s1_q;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            link_boot_q <= strap_s2_q;
        end
    end

    // ************************************************************
    // Boot sequencer
    // ************************************************************
    // The reset driver keeps reset long enough for the strap to settle.
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            state_q     <= ST_INIT;
            emi_cnt_q   <= EMI_CYCLES;
            boot_link_q <= '0;
            left_q      <= '0;
        end else if (CE_I) begin
            unique case (state_q)
                ST_INIT: begin
                    if (emi_cnt_q > 8'h01) begin
                        emi_cnt_q <= emi_cnt_q - 8'h01;
                    end else begin
                        state_q <= link_boot_q ? ST_WAIT : ST_ENTER;
                    end
                end
                ST_WAIT: begin
                    if (rx_valid != '0) begin
                        boot_link_q <= first_idx;
                        left_q      <= rx_data[first_idx];
                        state_q     <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (take[boot_link_q]) begin
                        left_q <= left_q - 8'h01;
                    end
                    if (left_q == '0 && !fifo_out_valid) begin
                        state_q <= ST_ENTER;
                    end
                end
                ST_ENTER: begin
                    state_q <= ST_RUN;
                end
                ST_RUN: begin
                    state_q <= ST_RUN;
                end
                default: begin
                    state_q <= ST_INIT;
                end
            endcase
        end
    end

    // ************************************************************
    // Start of execution
    // ************************************************************
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            START_O      <= 1'b0;
            START_ADDR_O <= ROM_ENTRY_ADDR;
        end else if (CE_I) begin
            START_O <= (state_q == ST_ENTER);
            if (state_q == ST_ENTER) begin
                START_ADDR_O <= link_boot_q ? LOAD_BASE_ADDR
                                            : ROM_ENTRY_ADDR;
            end
        end
    end

    // Links come alive as soon as the memory interface is ready.
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            EMI_INIT_O <= 1'b1;
            LINKS_EN_O <= 1'b0;
            PROC_RUN_O <= 1'b0;
        end else if (CE_I) begin
            EMI_INIT_O <= (state_q == ST_INIT);
            LINKS_EN_O <= (state_q != ST_INIT);
            PROC_RUN_O <= (state_q == ST_RUN) && !PROC_HALT_O;
        end
    end

    // ************************************************************
    // Channel bytes after boot
    // ************************************************************
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            CHAN_VALID_O <= 1'b0;
            CHAN_BYTE_O  <= '0;
        end else if (CE_I) begin
            CHAN_VALID_O <= (state_q == ST_RUN) && (run_oh != '0);
            if ((state_q == ST_RUN) && (run_oh != '0)) begin
                CHAN_BYTE_O.link <= run_idx;
                CHAN_BYTE_O.data <= rx_data[run_idx];
            end
        end
    end

    // ************************************************************
    // Error flag
    // ************************************************************
    assign any_err = SW_ERR_I.overflow | SW_ERR_I.bound | SW_ERR_I.div_zero;

    // A new error in the clearing cycle keeps the flag set.
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            err_q <= 1'b0;
        end else if (CE_I) begin
            err_q <= any_err | (err_q & ~ERR_CLR_I);
        end
    end

    assign ERROR_O = err_q;

    // Halting stops the core before it can spread a corrupt result.
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            PROC_HALT_O <= 1'b0;
        end else if (CE_I) begin
            PROC_HALT_O <= (err_q | any_err) & HALT_ON_ERR_I;
        end
    end

    // ************************************************************
    // Event pin
    // ************************************************************
    // Only the rising edge is passed on, one clock wide.
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            ev_s1_q <= 1'b0;
            ev_s2_q <= 1'b0;
            ev_s3_q <= 1'b0;
            EVENT_O <= 1'b0;
        end else if (CE_I) begin
            ev_s1_q <= EVENT_REQ_I;
            ev_s2_q <= ev_s1_q;
            ev_s3_q <= ev_s2_q;
            EVENT_O <= ev_s2_q & ~ev_s3_q;
        end
    end

    // Everything above runs on one clock; link bit timing is counted
    // from it rather than from a faster derived clock.

endmodule

//--- testbench/boot_checker.sv
/* Port assertions for the reset and boot loader.
   Assumes it is bound to reset_boot_loader and that CE_I stays high. */
`timescale 1ns/1ps
module boot_checker
    import boot_pkg::*;
(
    input wire logic                 CORE_CLK_I,
    input wire logic                 RST_N_I,
    input wire logic [NUM_LINKS-1:0] LINK_OUT_O,
    input wire logic [NUM_LINKS-1:0] LINK_INPUT_REQ_I,
    input wire logic                 CHAN_VALID_O,
    input wire logic                 EMI_INIT_O,
    input wire logic                 LINKS_EN_O,
    input wire logic                 PROC_RUN_O,
    input wire logic                 START_O,
    input wire logic [ADDR_W-1:0]    START_ADDR_O,
    input wire logic                 MEM_WR_VALID_O,
    input wire logic                 MEM_WR_READY_I,
    input wire mem_wr_t              MEM_WR_O,
    input wire sw_err_t              SW_ERR_I,
    input wire logic                 HALT_ON_ERR_I,
    input wire logic                 ERROR_O,
    input wire logic                 PROC_HALT_O,
    input wire logic                 EVENT_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    a_err_flag_set: assert property (
        |SW_ERR_I |=> ERROR_O) else $error("error flag not set");
    a_halt_on_err: assert property (
        |SW_ERR_I && HALT_ON_ERR_I |=> PROC_HALT_O)
        else $error("no halt on error");
    a_halt_stops_run: assert property (
        PROC_HALT_O |=> !PROC_RUN_O) else $error("run after halt");
    a_link_idle_low: assert property (
        !LINKS_EN_O |-> LINK_OUT_O == '0) else $error("link not idle");
    a_emi_before_links: assert property (
        $rose(LINKS_EN_O) |-> $past(EMI_INIT_O))
        else $error("links before memory init");
    a_start_target: assert property (
        START_O |-> LINKS_EN_O && (START_ADDR_O == ROM_ENTRY_ADDR
        || START_ADDR_O == LOAD_BASE_ADDR)) else $error("bad start");
    a_start_once: assert property (
        START_O |=> !START_O [*8]) else $error("start repeated");
    a_wr_held: assert property (
        MEM_WR_VALID_O && !MEM_WR_READY_I |=> MEM_WR_VALID_O
        && $stable(MEM_WR_O)) else $error("write dropped");
    a_addr_step: assert property (
        MEM_WR_VALID_O && MEM_WR_READY_I |=>
        MEM_WR_O.addr == $past(MEM_WR_O.addr) + 32'h1)
        else $error("address did not step");
    a_ack_width: assert property (
        $rose(LINK_OUT_O[2]) |-> LINK_OUT_O[2] [*8])
        else $error("ack too short");
    a_chan_needs_req: assert property (
        CHAN_VALID_O |-> |$past(LINK_INPUT_REQ_I))
        else $error("byte taken without input");
    a_event_pulse: assert property (
        EVENT_O |=> !EVENT_O) else $error("event pulse too long");
    c_link_start: cover property (START_O && START_ADDR_O == LOAD_BASE_ADDR);
    c_wr_stall: cover property (MEM_WR_VALID_O && !MEM_WR_READY_I);
    c_chan: cover property (CHAN_VALID_O);
endmodule

bind reset_boot_loader boot_checker u_chk (.CORE_CLK_I, .RST_N_I,
    .LINK_OUT_O, .LINK_INPUT_REQ_I, .CHAN_VALID_O, .EMI_INIT_O,
    .LINKS_EN_O, .PROC_RUN_O, .START_O, .START_ADDR_O, .MEM_WR_VALID_O,
    .MEM_WR_READY_I, .MEM_WR_O, .SW_ERR_I, .HALT_ON_ERR_I, .ERROR_O,
    .PROC_HALT_O, .EVENT_O);

//--- testbench/link_peer.sv
/* Neighbour node on one serial link: sends bytes, waits for acks.
   Assumes the loader's framing and ten clocks per bit. */
`timescale 1ns/1ps
module link_peer
    import boot_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic line_i,
    output logic      line_o
);
    logic got_ack;
    initial line_o = 1'b0;
    // The 3 ns skew keeps bit edges off the loader's clock edge.
    task automatic send(input logic [7:0] b);
        logic [10:0] f;
        int          i;
        f = {1'b0, b, 2'b11};
        got_ack = 1'b0;
        @(negedge clk_i);
        #3;
        for (i = 0; i < 11; i++) begin
            line_o = f[i];
            #(LINK_BIT_NS);
        end
        line_o = 1'b0;
        // Next byte after the ack or a 3000-clock timeout, so the loader sees whole messages.
        for (i = 0; i < 3000 && !got_ack; i++) begin
            @(posedge clk_i);
            got_ack = line_i;
        end
        repeat (20) @(posedge clk_i);
    endtask
endmodule

//--- testbench/testbench.sv
/* Self-checking bench for the reset and boot loader.
   Assumes link_peer partners on all four links and the bound checker. */
`timescale 1ns/1ps
module testbench
    import boot_pkg::*;
;
    logic                 clk, rst_n, strap, halt, clr, ev, rdy, cv;
    logic                 emi, len, run, st, wv, eo, ph, evo;
    logic [NUM_LINKS-1:0] lin, lout, req;
    logic [ADDR_W-1:0]    sa;
    sw_err_t              err;
    chan_byte_t           cb;
    mem_wr_t              wr;
    int                   fails, n_tests, ack0;
    logic [7:0]           wd [$];
    reset_boot_loader u_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
        .BOOT_FROM_LINK_I(strap), .LINK_IN_I(lin), .LINK_OUT_O(lout),
        .LINK_INPUT_REQ_I(req), .CHAN_VALID_O(cv), .CHAN_BYTE_O(cb),
        .EMI_INIT_O(emi), .LINKS_EN_O(len), .PROC_RUN_O(run),
        .START_O(st), .START_ADDR_O(sa), .MEM_WR_VALID_O(wv),
        .MEM_WR_READY_I(rdy), .MEM_WR_O(wr), .SW_ERR_I(err),
        .ERR_CLR_I(clr), .HALT_ON_ERR_I(halt), .ERROR_O(eo),
        .PROC_HALT_O(ph), .EVENT_REQ_I(ev), .EVENT_O(evo));
    for (genvar g = 0; g < NUM_LINKS; g++) begin : g_peer
        link_peer u_peer (.clk_i(clk), .line_i(lout[g]), .line_o(lin[g]));
    end
    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end

    task automatic chk(input string nm, input logic [39:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Every accepted write is logged; its address must follow the count.
    always @(posedge clk) begin
        if (wv === 1'b1 && rdy === 1'b1) begin
            chk("wr_addr", wr.addr, LOAD_BASE_ADDR + wd.size());
            wd.push_back(wr.data);
        end
        if (lout[0] === 1'b1 && req[0] !== 1'b1) ack0++;
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic do_reset(input logic s);
        @(negedge clk);
        rst_n = 1'b0;
        strap = s;
        repeat (20) @(negedge clk);
        chk("emi", emi, 1'b1);
        chk("links", len, 1'b0);
        chk("lout", lout, 4'h0);
        rst_n = 1'b1;
    endtask

    task automatic wait_start(input logic [31:0] a);
        int n;
        for (n = 0; n < 3000 && st !== 1'b1; n++) @(negedge clk);
        chk("start", st, 1'b1);
        chk("start_addr", sa, a);
        chk("links_on", len, 1'b1);
    endtask

    task automatic t_rom();
        do_reset(1'b0);
        wait_start(ROM_ENTRY_ADDR);
        @(negedge clk);
        chk("run", run, 1'b1);
        chk("lout_idle", lout, 4'h0);
    endtask

    task automatic t_err();
        int i;
        for (i = 0; i < 3; i++) begin
            err = sw_err_t'(3'h1 << i);
            @(negedge clk);
            err = 3'h0;
            chk("err_set", eo, 1'b1);
            chk("no_halt", ph, 1'b0);
            clr = 1'b1;
            @(negedge clk);
            clr = 1'b0;
            chk("err_clr", eo, 1'b0);
        end
        halt = 1'b1;
        err = 3'h4;
        @(negedge clk);
        err = 3'h0;
        chk("halt", ph, 1'b1);
        @(negedge clk);
        chk("run_off", run, 1'b0);
        halt = 1'b0;
    endtask

    task automatic t_event();
        int n;
        ev = 1'b1;
        for (n = 0; n < 10 && evo !== 1'b1; n++) @(negedge clk);
        chk("event", evo, 1'b1);
        @(negedge clk);
        chk("event_end", evo, 1'b0);
        ev = 1'b0;
    endtask

    // Memory stalls while nine bytes arrive, so the FIFO fills and refuses.
    task automatic t_link();
        int i, j;
        do_reset(1'b1);
        ack0 = 0;
        rdy = 1'b0;
        fork
            begin
                g_peer[2].u_peer.send(8'h09);
                for (j = 0; j < 9; j++) g_peer[2].u_peer.send(8'hA0 + 8'(j));
            end
            begin
                repeat (300) @(negedge clk);
                g_peer[0].u_peer.send(8'h5C);
            end
        join_none
        repeat (1500) @(negedge clk);
        chk("stalled", wd.size(), 0);
        chk("wr_hold", wv, 1'b1);
        rdy = 1'b1;
        wait_start(LOAD_BASE_ADDR);
        chk("count", wd.size(), 9);
        for (i = 0; i < 9 && i < wd.size(); i++)
            chk("data", wd[i], 8'hA0 + 8'(i));
        chk("ack0", ack0, 0);
        req[0] = 1'b1;
        for (i = 0; i < 20 && cv !== 1'b1; i++) @(negedge clk);
        chk("chan", cb, {2'h0, 8'h5C});
        wait fork;
        chk("acked", g_peer[0].u_peer.got_ack, 1'b1);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        finish_test();
    end

    initial begin
        {rst_n, strap, halt, clr, ev, rdy, req, err} = '0;
        t_rom();
        t_err();
        t_event();
        t_link();
        finish_test();
    end
endmodule
